/* File: pkg/mgmt_access_if.sv */
// Purpose: register access path between the frame engine and the register bank
// Assumes: rd_req and wr_req are one-cycle pulses, rdata is combinational
// Notes:   addr stays valid from header end to frame end
`timescale 1ns/10ps
interface mgmt_access_if;
  logic        rd_req;
  logic        wr_req;
  logic [4:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;

  modport engine (output rd_req, output wr_req, output addr, output wdata, input rdata);
  modport regs   (input rd_req, input wr_req, input addr, input wdata, output rdata);
endinterface : mgmt_access_if

/* File: pkg/phy_mgmt_pkg.sv */
// Purpose: shared constants and types for the per-port management register bank
// Assumes: one PHY address per instance, clause-22 style management frames
// Notes:   offsets are management register numbers, not byte addresses
package phy_mgmt_pkg;

  // register numbers on the management interface
  localparam logic [4:0] ADV_OFFSET      = 5'h04;
  localparam logic [4:0] PARTNER_OFFSET  = 5'h05;
  localparam logic [4:0] DIAG_OFFSET     = 5'h1D;
  localparam logic [4:0] PHY_ADDR        = 5'h01;

  // field positions
  localparam int ADV_100FD_BIT           = 8;
  localparam int ADV_10HD_BIT            = 5;
  localparam int PAUSE_BIT               = 10;
  localparam int DIAG_START_BIT          = 15;
  localparam int DIAG_RESULT_MSB         = 14;
  localparam int DIAG_RESULT_LSB         = 13;
  localparam int DIAG_SHORT_BIT          = 12;
  localparam int DIAG_COUNT_MSB          = 8;

  // values after reset and fixed fields
  localparam logic [3:0]  ADV_RESET      = 4'hF;
  localparam logic [4:0]  SELECTOR_VALUE = 5'h01;
  localparam logic [1:0]  RESULT_NORMAL  = 2'h0;
  localparam logic [1:0]  RESULT_OPEN    = 2'h1;
  localparam logic [1:0]  RESULT_SHORT   = 2'h2;
  localparam logic [1:0]  RESULT_FAILED  = 2'h3;
  localparam logic [8:0]  COUNT_RESET    = 9'h000;

  // frame layout, counted in management clock periods
  localparam logic [5:0]  PREAMBLE_BITS  = 6'h20;
  localparam logic [5:0]  HEADER_LAST    = 6'h0C;
  localparam logic [5:0]  TURN_LAST      = 6'h01;
  localparam logic [5:0]  DATA_LAST      = 6'h0F;
  localparam logic [1:0]  OP_READ        = 2'h2;
  localparam logic [1:0]  OP_WRITE       = 2'h1;

  typedef enum logic [1:0] {ST_PREAMBLE, ST_HEADER, ST_TURN, ST_DATA} mdio_state_t;

endpackage : phy_mgmt_pkg

/* File: src/mdio_frame_engine.sv */
// Purpose: management frame receiver and read-data driver on the serial data pin
// Assumes: mdc and mdio inputs are synchronous to clock_in and much slower
// Notes:   bits are taken on each rising edge of mdc; read data changes there too
`timescale 1ns/10ps
module mdio_frame_engine (
  // clock and reset
  input  wire logic   clock_in,
  input  wire logic   rst_b_in,
  // management pins
  input  wire logic   mdc_in,
  input  wire logic   mdio_in,
  output logic        mdio_out,
  output logic        mdio_oe_out,
  // register access
  mgmt_access_if.engine bus
);

  phy_mgmt_pkg::mdio_state_t state, next_state;
  logic [5:0]  cnt,      next_cnt;
  logic [12:0] hdr,      next_hdr;
  logic [15:0] shreg,    next_shreg;
  logic        active,   next_active;
  logic        is_read,  next_is_read;
  logic        drive,    next_drive;
  logic        out_bit,  next_out_bit;
  logic        mdc_prev;
  logic        mdc_rise;
  logic [12:0] full_hdr;

  assign mdc_rise    = mdc_in & ~mdc_prev;
  assign full_hdr    = {hdr[11:0], mdio_in};
  assign bus.addr    = hdr[4:0];
  assign bus.wdata   = {shreg[14:0], mdio_in};
  assign mdio_out    = out_bit;
  assign mdio_oe_out = drive;

  always_comb begin
    next_state   = state;
    next_cnt     = cnt;
    next_hdr     = hdr;
    next_shreg   = shreg;
    next_active  = active;
    next_is_read = is_read;
    next_drive   = drive;
    next_out_bit = out_bit;
    bus.rd_req   = 1'b0;
    bus.wr_req   = 1'b0;
    if (mdc_rise) begin
      case (state)
        phy_mgmt_pkg::ST_PREAMBLE: begin
          if (mdio_in) begin
            if (cnt != phy_mgmt_pkg::PREAMBLE_BITS) next_cnt = cnt + 6'h01;
          end else if (cnt == phy_mgmt_pkg::PREAMBLE_BITS) begin
            next_cnt   = 6'h00;
            next_state = phy_mgmt_pkg::ST_HEADER;
          end else begin
            next_cnt = 6'h00;
          end
        end
        phy_mgmt_pkg::ST_HEADER: begin
          next_hdr = full_hdr;
          next_cnt = cnt + 6'h01;
          if (cnt == phy_mgmt_pkg::HEADER_LAST) begin
            next_cnt     = 6'h00;
            next_state   = phy_mgmt_pkg::ST_TURN;
            next_is_read = full_hdr[11:10] == phy_mgmt_pkg::OP_READ;
            next_active  = full_hdr[12] && full_hdr[9:5] == phy_mgmt_pkg::PHY_ADDR &&
                           (full_hdr[11:10] == phy_mgmt_pkg::OP_READ ||
                            full_hdr[11:10] == phy_mgmt_pkg::OP_WRITE);
          end
        end
        phy_mgmt_pkg::ST_TURN: begin
          next_cnt = cnt + 6'h01;
          if (cnt == 6'h00) begin
            if (active && is_read) begin
              bus.rd_req   = 1'b1;
              next_shreg   = bus.rdata;
              next_drive   = 1'b1;
              next_out_bit = 1'b0;
            end
          end else begin
            next_cnt   = 6'h00;
            next_state = phy_mgmt_pkg::ST_DATA;
            if (active && is_read) begin
              next_out_bit = shreg[15];
              next_shreg   = {shreg[14:0], 1'b0};
            end
          end
        end
        phy_mgmt_pkg::ST_DATA: begin
          next_cnt = cnt + 6'h01;
          if (active && is_read) begin
            next_out_bit = shreg[15];
            next_shreg   = {shreg[14:0], 1'b0};
          end else begin
            next_shreg = {shreg[14:0], mdio_in};
          end
          if (cnt == phy_mgmt_pkg::DATA_LAST) begin
            bus.wr_req   = active && !is_read;
            next_drive   = 1'b0;
            next_out_bit = 1'b0;
            next_cnt     = 6'h00;
            next_active  = 1'b0;
            next_state   = phy_mgmt_pkg::ST_PREAMBLE;
          end
        end
        default: begin
          next_state = phy_mgmt_pkg::ST_PREAMBLE;
          next_cnt   = 6'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      state    <= phy_mgmt_pkg::ST_PREAMBLE;
      cnt      <= 6'h00;
      hdr      <= 13'h0000;
      shreg    <= 16'h0000;
      active   <= 1'b0;
      is_read  <= 1'b0;
      drive    <= 1'b0;
      out_bit  <= 1'b0;
      mdc_prev <= 1'b0;
    end else begin
      state    <= next_state;
      cnt      <= next_cnt;
      hdr      <= next_hdr;
      shreg    <= next_shreg;
      active   <= next_active;
      is_read  <= next_is_read;
      drive    <= next_drive;
      out_bit  <= next_out_bit;
      mdc_prev <= mdc_in;
    end
  end

endmodule : mdio_frame_engine

/* File: src/phy_autoneg_cable_diag_regs.sv */
// Purpose: advertisement, partner ability and cable diagnostic management registers
// Assumes: negotiation engine and cable measurement engine sit outside this block
// Notes:   registers are reached only through the serial management frames
`timescale 1ns/10ps

// Operation
// - advertisement bit 8, read/write, resets to 1, offers 100 full duplex
// - advertisement bit 7, read/write, resets to 1, offers 100 half duplex
// - advertisement bit 6, read/write, resets to 1, offers 10 full duplex
// - advertisement bit 5, read/write, resets to 1, offers 10 half duplex
// - partner register bit 10 reports partner pause ability, resets to 0
// - partner register bit 8 reports partner 100 full duplex, resets to 0
// - partner register bit 7 reports partner 100 half duplex, resets to 0
// - partner register bit 6 reports partner 10 full duplex, resets to 0
// - partner register bit 5 reports partner 10 half duplex, resets to 0
// - writing 1 to diagnostic bit 15 starts a test unless one is still running; it clears when done
// - reading 0 from the start bit means results are valid; poll first
// - bits 14-13 give outcome: normal, open, short, or test failed
// - bit 12 flags a short closer than ten metres
// - bits 8-0 hold fault distance count, about 0.4 metre per step
module phy_autoneg_cable_diag_regs (
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_b_in,
  // management pins
  input  wire logic        mdc_in,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe_out,
  // negotiation engine
  input  wire logic        lcw_valid_in,
  input  wire logic [15:0] lcw_in,
  output logic      [3:0]  adv_ability_out,
  // cable measurement engine
  output logic             cable_test_start_out,
  input  wire logic        cable_test_done_in,
  input  wire logic [1:0]  cable_result_in,
  input  wire logic        cable_short_in,
  input  wire logic [8:0]  cable_count_in
);

  mgmt_access_if bus ();

  logic [3:0] adv,           next_adv;
  logic       lp_pause,      next_lp_pause;
  logic [3:0] lp_ability,    next_lp_ability;
  logic       diag_busy,     next_diag_busy;
  logic [1:0] diag_result,   next_diag_result;
  logic       diag_short,    next_diag_short;
  logic [8:0] diag_count,    next_diag_count;
  logic       start_pulse,   next_start_pulse;
  logic [15:0] adv_word;
  logic [15:0] partner_word;
  logic [15:0] diag_word;
  logic       diag_done;

  function automatic logic writes(input logic wr, input logic [4:0] a, input logic [4:0] off);
    writes = wr && (a == off);
  endfunction : writes

  mdio_frame_engine engine (
    .clock_in    (clock_in),
    .rst_b_in    (rst_b_in),
    .mdc_in      (mdc_in),
    .mdio_in     (mdio_in),
    .mdio_out    (mdio_out),
    .mdio_oe_out (mdio_oe_out),
    .bus         (bus)
  );

  // read views; unsupported and reserved bits read zero
  assign adv_word     = {7'h00, adv, phy_mgmt_pkg::SELECTOR_VALUE};
  assign partner_word = {5'h00, lp_pause, 1'b0, lp_ability,
                         phy_mgmt_pkg::SELECTOR_VALUE};
  assign diag_word    = {diag_busy, diag_result, diag_short, 3'h0, diag_count};

  always_comb begin
    case (bus.addr)
      phy_mgmt_pkg::ADV_OFFSET:     bus.rdata = adv_word;
      phy_mgmt_pkg::PARTNER_OFFSET: bus.rdata = partner_word;
      phy_mgmt_pkg::DIAG_OFFSET:    bus.rdata = diag_word;
      default:                      bus.rdata = 16'h0000;
    endcase
  end

  assign adv_ability_out      = adv;
  assign cable_test_start_out = start_pulse;
  assign diag_done            = diag_busy && cable_test_done_in;

  always_comb begin
    next_adv         = adv;
    next_lp_pause    = lp_pause;
    next_lp_ability  = lp_ability;
    next_diag_busy   = diag_busy;
    next_diag_result = diag_result;
    next_diag_short  = diag_short;
    next_diag_count  = diag_count;
    next_start_pulse = 1'b0;
    if (writes(bus.wr_req, bus.addr, phy_mgmt_pkg::ADV_OFFSET)) begin
      next_adv = bus.wdata[phy_mgmt_pkg::ADV_100FD_BIT:phy_mgmt_pkg::ADV_10HD_BIT];
    end
    if (lcw_valid_in) begin
      next_lp_pause   = lcw_in[phy_mgmt_pkg::PAUSE_BIT];
      next_lp_ability = lcw_in[phy_mgmt_pkg::ADV_100FD_BIT:phy_mgmt_pkg::ADV_10HD_BIT];
    end
    if (diag_done) begin
      next_diag_busy   = 1'b0;
      next_diag_result = cable_result_in;
      next_diag_short  = cable_short_in;
      next_diag_count  = cable_count_in;
    end
    // a new start taken in the finishing cycle wins over the self clear
    if (writes(bus.wr_req, bus.addr, phy_mgmt_pkg::DIAG_OFFSET) &&
        bus.wdata[phy_mgmt_pkg::DIAG_START_BIT] && (!diag_busy || diag_done)) begin
      next_diag_busy   = 1'b1;
      next_start_pulse = 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      adv         <= phy_mgmt_pkg::ADV_RESET;
      lp_pause    <= 1'b0;
      lp_ability  <= 4'h0;
      diag_busy   <= 1'b0;
      diag_result <= phy_mgmt_pkg::RESULT_NORMAL;
      diag_short  <= 1'b0;
      diag_count  <= phy_mgmt_pkg::COUNT_RESET;
      start_pulse <= 1'b0;
    end else begin
      adv         <= next_adv;
      lp_pause    <= next_lp_pause;
      lp_ability  <= next_lp_ability;
      diag_busy   <= next_diag_busy;
      diag_result <= next_diag_result;
      diag_short  <= next_diag_short;
      diag_count  <= next_diag_count;
      start_pulse <= next_start_pulse;
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);

  // each advertisement bit follows the last write to its position
  a_adv_100fd_write: assert property (
    writes(bus.wr_req, bus.addr, phy_mgmt_pkg::ADV_OFFSET)
      |=> adv_ability_out[3] == $past(bus.wdata[8]))
    else $error("100 full advertisement did not take the written value");
  a_adv_100hd_write: assert property (
    writes(bus.wr_req, bus.addr, phy_mgmt_pkg::ADV_OFFSET)
      |=> adv_ability_out[2] == $past(bus.wdata[7]))
    else $error("100 half advertisement did not take the written value");
  a_adv_10fd_write: assert property (
    writes(bus.wr_req, bus.addr, phy_mgmt_pkg::ADV_OFFSET)
      |=> adv_ability_out[1] == $past(bus.wdata[6]))
    else $error("10 full advertisement did not take the written value");
  a_adv_10hd_write: assert property (
    writes(bus.wr_req, bus.addr, phy_mgmt_pkg::ADV_OFFSET)
      |=> adv_ability_out[0] == $past(bus.wdata[5]))
    else $error("10 half advertisement did not take the written value");
  a_adv_100hd_read: assert property (
    bus.rd_req && bus.addr == phy_mgmt_pkg::ADV_OFFSET |-> bus.rdata[7] == adv_ability_out[2])
    else $error("100 half advertisement read differs from offered value");
  a_adv_10fd_hold: assert property (
    !writes(bus.wr_req, bus.addr, phy_mgmt_pkg::ADV_OFFSET) |=> $stable(adv_ability_out[1]))
    else $error("10 full advertisement changed without a write");
  a_adv_10hd_reset: assert property (
    $rose(rst_b_in) |-> adv_ability_out[0] && adv_word[4:0] == 5'h01)
    else $error("10 half advertisement not set after reset");
  a_lp_pause_capture: assert property (
    lcw_valid_in |=> partner_word[10] == $past(lcw_in[10]))
    else $error("partner pause bit not taken from code word");
  a_lp_ability_capture: assert property (
    lcw_valid_in |=> partner_word[8:5] == $past(lcw_in[8:5]) && partner_word[9] == 1'b0)
    else $error("partner ability bits not taken from code word");
  a_lp_100hd_capture: assert property (
    lcw_valid_in |=> partner_word[7] == $past(lcw_in[7]))
    else $error("partner 100 half bit not taken from code word");
  a_lp_10fd_capture: assert property (
    lcw_valid_in |=> partner_word[6] == $past(lcw_in[6]))
    else $error("partner 10 full bit not taken from code word");
  a_lp_10hd_capture: assert property (
    lcw_valid_in |=> partner_word[5] == $past(lcw_in[5]))
    else $error("partner 10 half bit not taken from code word");
  a_lp_ro_ignore: assert property (
    writes(bus.wr_req, bus.addr, phy_mgmt_pkg::PARTNER_OFFSET) && !lcw_valid_in
      |=> $stable(partner_word))
    else $error("write changed the read-only partner register");
  a_diag_self_clear: assert property (
    diag_done && !bus.wr_req |=> !diag_word[15] && !cable_test_start_out)
    else $error("start bit did not self clear on completion");
  a_diag_start_busy: assert property (
    cable_test_start_out |-> diag_word[15] ##1 !cable_test_start_out)
    else $error("start pulse without busy start bit or longer than a cycle");
  // a start write is taken only by an idle tester or in the finishing cycle; other writes while busy neither restart nor abort
  a_diag_start_take: assert property (
    writes(bus.wr_req, bus.addr, phy_mgmt_pkg::DIAG_OFFSET) && bus.wdata[15] && !diag_busy
      |=> cable_test_start_out && diag_word[15])
    else $error("start write on an idle tester did not start a test");
  a_diag_start_ignored: assert property (
    writes(bus.wr_req, bus.addr, phy_mgmt_pkg::DIAG_OFFSET) && diag_busy && !diag_done
      |=> !cable_test_start_out && diag_word[15])
    else $error("write during a running test restarted or aborted it");
  a_diag_done_ignored: assert property (
    cable_test_done_in && !diag_busy && !bus.wr_req |=> $stable(diag_word))
    else $error("completion without a running test changed the results");
  a_diag_result_capture: assert property (
    diag_done |=> diag_word[14:13] == $past(cable_result_in))
    else $error("result code not captured on completion");
  a_diag_short_capture: assert property (
    diag_done |=> diag_word[12] == $past(cable_short_in))
    else $error("short flag not captured on completion");
  a_diag_count_capture: assert property (
    diag_done |=> diag_word[8:0] == $past(cable_count_in) && diag_word[11:9] == 3'h0)
    else $error("fault count not captured on completion");
  a_diag_result_hold: assert property (
    !diag_done |=> $stable(diag_word[14:0]))
    else $error("diagnostic results changed between tests");

  c_adv_written:  cover property (writes(bus.wr_req, bus.addr, phy_mgmt_pkg::ADV_OFFSET));
  c_partner_read: cover property (bus.rd_req && bus.addr == phy_mgmt_pkg::PARTNER_OFFSET);
  c_test_cycle:   cover property (cable_test_start_out ##[1:200] diag_done);
  c_test_short:   cover property (diag_done && cable_result_in == phy_mgmt_pkg::RESULT_SHORT);
  c_start_busy:   cover property (writes(bus.wr_req, bus.addr, phy_mgmt_pkg::DIAG_OFFSET) && diag_busy);

endmodule : phy_autoneg_cable_diag_regs

/* File: tb/mgmt_host_model.sv */
// Purpose: station management controller model that runs framed reads and writes
// Assumes: frame() is entered just after a clock edge
// Notes:   the data pin is pulled up whenever nobody drives it
`timescale 1ns/10ps
module mgmt_host_model (
  // clock
  input  wire logic        clock_in,
  // device side of the data pin
  input  wire logic        dev_data_in,
  input  wire logic        dev_oe_in,
  // management pins
  output logic             mdc_out,
  output logic             mdio_wire_out,
  // captured read data
  output logic             rd_valid_out,
  output logic      [15:0] rd_data_out
);
  logic host_bit;
  logic host_oe;

  // pull-up takes the pin high once both sides release it
  assign mdio_wire_out = dev_oe_in ? dev_data_in : (host_oe ? host_bit : 1'h1);

  initial begin
    mdc_out = 1'h0;
    host_bit = 1'h1;
    host_oe = 1'h0;
    rd_valid_out = 1'h0;
    rd_data_out = 16'h0000;
  end

  // one frame: preamble, start, op, addresses, turnaround, data; mdc idles low after
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                       input logic [15:0] wd);
    logic [63:0] bits;
    logic [15:0] cap;
    int          k;
    bits = {32'hFFFFFFFF, 2'h1, op, phy, ra, 2'h2, wd};
    cap = 16'h0000;
    for (k = 63; k >= 0; k--) begin
      host_bit = bits[k];
      // a read hands the pin over from the first turnaround bit on
      host_oe = (op != phy_mgmt_pkg::OP_READ) || (k > 17);
      repeat (4) @(posedge clock_in);
      #1;
      cap = {cap[14:0], mdio_wire_out};
      mdc_out = 1'h1;
      repeat (4) @(posedge clock_in);
      #1;
      mdc_out = 1'h0;
    end
    host_oe = 1'h0;
    if (op == phy_mgmt_pkg::OP_READ) begin
      rd_data_out = cap;
      rd_valid_out = 1'h1;
      @(posedge clock_in);
      #1;
      rd_valid_out = 1'h0;
    end
    repeat (8) @(posedge clock_in);
    #1;
  endtask : frame
endmodule : mgmt_host_model

/* File: tb/testbench.sv */
// Purpose: self-checking bench for the advertisement, partner and diagnostic registers
// Assumes: registers reached only through management frames from the host model
// Notes:   reads queue their expected word; a monitor compares when data returns
`timescale 1ns/10ps
module testbench;
  localparam logic [4:0] ADDR = phy_mgmt_pkg::PHY_ADDR;
  localparam logic [4:0] ADV = phy_mgmt_pkg::ADV_OFFSET;
  localparam logic [4:0] PART = phy_mgmt_pkg::PARTNER_OFFSET;
  localparam logic [4:0] DIAG = phy_mgmt_pkg::DIAG_OFFSET;

  logic        clock_in;
  logic        rst_b;
  logic        mdc;
  logic        mdio_wire;
  logic        dev_data;
  logic        dev_oe;
  logic        lcw_valid;
  logic [15:0] lcw;
  logic [3:0]  adv;
  logic        test_start;
  logic        test_done;
  logic [1:0]  result;
  logic        short_flag;
  logic [8:0]  count;
  logic        rd_valid;
  logic [15:0] rd_data;
  logic [15:0] exp_q[$];
  logic [15:0] wd;
  logic [15:0] held;
  int          n_errors;
  int          comparisons;
  int          n_starts;
  int          cycles;
  int          i;

  phy_autoneg_cable_diag_regs uut (
    .clock_in(clock_in), .rst_b_in(rst_b), .mdc_in(mdc), .mdio_in(mdio_wire),
    .mdio_out(dev_data), .mdio_oe_out(dev_oe), .lcw_valid_in(lcw_valid), .lcw_in(lcw),
    .adv_ability_out(adv), .cable_test_start_out(test_start),
    .cable_test_done_in(test_done), .cable_result_in(result),
    .cable_short_in(short_flag), .cable_count_in(count));

  mgmt_host_model mgmt (
    .clock_in(clock_in), .dev_data_in(dev_data), .dev_oe_in(dev_oe), .mdc_out(mdc),
    .mdio_wire_out(mdio_wire), .rd_valid_out(rd_valid), .rd_data_out(rd_data));

  initial clock_in = 1'h0;
  always #5 clock_in = ~clock_in;

  task automatic check16(input string what, input logic [15:0] expv, input logic [15:0] got);
    comparisons++;
    if (got !== expv) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, expv, got);
    end
  endtask : check16

  task automatic report_and_stop();
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic rd(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] expv);
    exp_q.push_back(expv);
    mgmt.frame(phy_mgmt_pkg::OP_READ, phy, ra, 16'h0000);
  endtask : rd

  task automatic wr(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] d);
    mgmt.frame(phy_mgmt_pkg::OP_WRITE, phy, ra, d);
  endtask : wr

  // completion pulse; inputs scrambled afterwards so held results can be seen
  task automatic finish_test(input logic [1:0] r, input logic s, input logic [8:0] c);
    test_done = 1'h1;
    result = r;
    short_flag = s;
    count = c;
    @(posedge clock_in);
    #1;
    test_done = 1'h0;
    result = ~r;
    short_flag = ~s;
    count = ~c;
  endtask : finish_test

  always @(posedge clock_in) begin
    cycles++;
    if (test_start === 1'h1) n_starts++;
    if (rd_valid === 1'h1) begin
      if (exp_q.size() > 0) begin
        check16("read data", exp_q.pop_front(), rd_data);
      end else begin
        n_errors++;
        $display("CHECK FAILED read data expected none seen %h", rd_data);
      end
    end
    if (cycles == 40000) begin
      n_errors++;
      report_and_stop();
    end
  end

  initial begin
    rst_b = 1'h0;
    lcw_valid = 1'h0;
    lcw = 16'h0000;
    test_done = 1'h0;
    result = 2'h0;
    short_flag = 1'h0;
    count = 9'h000;
    wd = 16'($urandom(20));
    repeat (20) @(posedge clock_in);
    #1;
    rst_b = 1'h1;
    @(posedge clock_in);
    #1;
    check16("adv pins", 16'h000F, {12'h000, adv});
    rd(ADDR, ADV, 16'h01E1);
    rd(ADDR, PART, 16'h0001);
    rd(ADDR, DIAG, 16'h0000);
    for (i = 0; i < 6; i++) begin
      wd = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : 16'($urandom);
      wr(ADDR, ADV, wd);
      check16("adv pins", {12'h000, wd[8:5]}, {12'h000, adv});
      rd(ADDR, ADV, (wd & 16'h01E0) | 16'h0001);
    end
    // foreign address: pin never driven, register untouched
    wr(5'h1E, ADV, ~wd);
    rd(5'h1E, ADV, 16'hFFFF);
    // undefined opcode: frame is ignored and the register keeps its value
    mgmt.frame(2'h3, ADDR, ADV, ~wd);
    rd(ADDR, ADV, (wd & 16'h01E0) | 16'h0001);
    rd(ADDR, 5'h10, 16'h0000);
    wr(ADDR, PART, 16'hFFFF);
    rd(ADDR, PART, 16'h0001);
    for (i = 0; i < 3; i++) begin
      wd = (i == 0) ? 16'hFFFF : 16'($urandom);
      lcw = wd;
      lcw_valid = 1'h1;
      @(posedge clock_in);
      #1;
      lcw_valid = 1'h0;
      lcw = ~wd;
      rd(ADDR, PART, (wd & 16'h05E0) | 16'h0001);
    end
    // completion with no test running is ignored
    finish_test(2'h3, 1'h1, 9'h1FF);
    rd(ADDR, DIAG, 16'h0000);
    held = 16'h0000;
    for (i = 0; i < 4; i++) begin
      wr(ADDR, DIAG, 16'h8000);
      rd(ADDR, DIAG, 16'h8000 | held);
      wr(ADDR, DIAG, 16'h8000);
      wr(ADDR, DIAG, 16'h0000);
      rd(ADDR, DIAG, 16'h8000 | held);
      wd = 16'($urandom);
      finish_test(2'(i), wd[9], wd[8:0]);
      held = {1'h0, 2'(i), wd[9], 3'h0, wd[8:0]};
      rd(ADDR, DIAG, held);
    end
    wr(ADDR, DIAG, 16'h7FFF);
    rd(ADDR, DIAG, held);
    check16("start pulses", 16'h0004, 16'(n_starts));
    check16("reads pending", 16'h0000, 16'(exp_q.size()));
    report_and_stop();
  end
endmodule : testbench
